/* src/pin_mux_defines.svh */
// reset values and field positions for the quad0 / spi0 pin mux
// assumes inclusion by bare name from design and bench files
`ifndef PIN_MUX_DEFINES_SVH
`define PIN_MUX_DEFINES_SVH
`define PC_INDEX_BIT 6
`define PC_HOME_BIT 7
`define PE_SCLK_BIT 4
`define PE_MOSI_BIT 5
`define PE_MISO_BIT 6
`define PE_SS_BIT 7
`define PULLUP_RESET 8'hff
`define SEL_RESET 2'h0
`endif

/* src/pin_mux_pkg.sv */
// types shared by the pin mux and its bench
// assumes nothing beyond a systemverilog compiler
`default_nettype none
package pin_mux_pkg;
  // per-pin function select code
  typedef enum logic [1:0] {
    fn_default = 2'h0,
    fn_alternate = 2'h1,
    fn_gpio = 2'h2
  } pin_func_type;
endpackage : pin_mux_pkg
`default_nettype wire

/* src/quad0_spi0_pin_mux.sv */
// pin mux for decoder-0 index/home and spi0 pins, with pull-up enables
// assumes pins are resolved outside; output enables are active low (low = drive)
//
// Contract
// - after reset index pin feeds decoder-0 index input
// - after reset home pin feeds decoder-0 home input
// - index pin may instead carry timer A channel two, bidirectional
// - home pin may instead carry timer A channel three, bidirectional
// - port C bit six clear removes index pin pull-up
// - port C bit seven clear removes home pin pull-up
// - port E bit four clear removes serial clock pull-up
// - port E bit five clear removes master-out pull-up
// - port E bit six clear removes master-in pull-up
// - port E bit seven clear removes slave-select pull-up
// - after reset port E bit four is spi0 serial clock
// - after reset port E bit five is spi0 master-out
// - after reset port E bit six is spi0 master-in
// - as master, serial clock pin is driven out
// - as slave, serial clock pin is an input clock
// - master drives master-out, slave receives it
// - master data leads sampling edge by half a clock
// - slave drives master-in, master receives it
// - unselected slave leaves master-in undriven
// - slave data leads sampling edge by half a clock
// - slave-select tells spi that transfer is for it
// - each gpio pin is individually input or output
`default_nettype none
`include "pin_mux_defines.svh"
module quad0_spi0_pin_mux #(
  parameter int unsigned NPINS = 6
) (
  input wire logic mclk,
  input wire logic rst_b,
  // function selects, written into per-pin registers
  input wire logic [1:0] index_sel,
  input wire logic [1:0] home_sel,
  input wire logic [1:0] sclk_sel,
  input wire logic [1:0] mosi_sel,
  input wire logic [1:0] miso_sel,
  input wire logic [1:0] ss_sel,
  input wire logic sel_write,
  // pull-up enable registers
  input wire logic [7:0] port_c_pullup_wdata,
  input wire logic port_c_pullup_write,
  input wire logic [7:0] port_e_pullup_wdata,
  input wire logic port_e_pullup_write,
  output logic [7:0] port_c_pullup_enable,
  output logic [7:0] port_e_pullup_enable,
  // gpio per pin: order index, home, sclk, mosi, miso, ss
  input wire logic [NPINS-1:0] gpio_out,
  input wire logic [NPINS-1:0] gpio_dir_out,
  output logic [NPINS-1:0] gpio_in,
  // timer channels
  input wire logic timer_a_channel_two_out,
  input wire logic timer_a_channel_two_oe,
  output logic timer_a_channel_two_in,
  input wire logic timer_a_channel_three_out,
  input wire logic timer_a_channel_three_oe,
  output logic timer_a_channel_three_in,
  output logic quad0_index_input,
  output logic quad0_home_input,
  // spi core side, data already aligned half a clock ahead by the core
  input wire logic spi0_master_mode,
  input wire logic spi0_clock_out,
  input wire logic spi0_mosi_out,
  input wire logic spi0_miso_out,
  output logic spi0_clock_in,
  output logic spi0_mosi_in,
  output logic spi0_miso_in,
  output logic spi0_selected,
  // pad side: pin_i from pad, pin_o to pad, pin_oe_b low = driving
  input wire logic [NPINS-1:0] pin_i,
  output logic [NPINS-1:0] pin_o,
  output logic [NPINS-1:0] pin_oe_b,
  output logic [NPINS-1:0] pin_pullup
);

  localparam int unsigned P_INDEX = 0;
  localparam int unsigned P_HOME = 1;
  localparam int unsigned P_SCLK = 2;
  localparam int unsigned P_MOSI = 3;
  localparam int unsigned P_MISO = 4;
  localparam int unsigned P_SS = 5;

  pin_mux_pkg::pin_func_type sel_reg [NPINS];
  logic [NPINS-1:0] o_next;
  logic [NPINS-1:0] drive_next;
  logic selected;

  ////////////////////////////////////////////////////////////////////////
  // function select registers, default function after reset
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NPINS; i++) begin
        sel_reg[i] <= pin_mux_pkg::fn_default;
      end
    end else if (sel_write) begin
      sel_reg[P_INDEX] <= pin_mux_pkg::pin_func_type'(index_sel);
      sel_reg[P_HOME] <= pin_mux_pkg::pin_func_type'(home_sel);
      sel_reg[P_SCLK] <= pin_mux_pkg::pin_func_type'(sclk_sel);
      sel_reg[P_MOSI] <= pin_mux_pkg::pin_func_type'(mosi_sel);
      sel_reg[P_MISO] <= pin_mux_pkg::pin_func_type'(miso_sel);
      sel_reg[P_SS] <= pin_mux_pkg::pin_func_type'(ss_sel);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pull-up enable registers, all enabled out of reset
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      port_c_pullup_enable <= `PULLUP_RESET;
    end else if (port_c_pullup_write) begin
      port_c_pullup_enable <= port_c_pullup_wdata;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      port_e_pullup_enable <= `PULLUP_RESET;
    end else if (port_e_pullup_write) begin
      port_e_pullup_enable <= port_e_pullup_wdata;
    end
  end

  // pull-up presented to the pad, registered so it follows the enable by one edge
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pin_pullup <= {NPINS{1'b1}};
    end else begin
      pin_pullup[P_INDEX] <= port_c_pullup_enable[`PC_INDEX_BIT];
      pin_pullup[P_HOME] <= port_c_pullup_enable[`PC_HOME_BIT];
      pin_pullup[P_SCLK] <= port_e_pullup_enable[`PE_SCLK_BIT];
      pin_pullup[P_MOSI] <= port_e_pullup_enable[`PE_MOSI_BIT];
      pin_pullup[P_MISO] <= port_e_pullup_enable[`PE_MISO_BIT];
      pin_pullup[P_SS] <= port_e_pullup_enable[`PE_SS_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // slave select is active low; only honoured when the pin is in spi use
  assign selected = (sel_reg[P_SS] == pin_mux_pkg::fn_default) && !pin_i[P_SS];

  // pad drive decision per pin
  always_comb begin
    o_next = '0;
    drive_next = '0;
    for (int i = 0; i < NPINS; i++) begin
      if (sel_reg[i] == pin_mux_pkg::fn_gpio) begin
        o_next[i] = gpio_out[i];
        drive_next[i] = gpio_dir_out[i];
      end
    end
    // decoder inputs never drive; timer alternates drive when the timer asks
    if (sel_reg[P_INDEX] == pin_mux_pkg::fn_alternate) begin
      o_next[P_INDEX] = timer_a_channel_two_out;
      drive_next[P_INDEX] = timer_a_channel_two_oe;
    end
    if (sel_reg[P_HOME] == pin_mux_pkg::fn_alternate) begin
      o_next[P_HOME] = timer_a_channel_three_out;
      drive_next[P_HOME] = timer_a_channel_three_oe;
    end
    if (sel_reg[P_SCLK] == pin_mux_pkg::fn_default) begin
      o_next[P_SCLK] = spi0_clock_out;
      drive_next[P_SCLK] = spi0_master_mode;
    end
    if (sel_reg[P_MOSI] == pin_mux_pkg::fn_default) begin
      o_next[P_MOSI] = spi0_mosi_out;
      drive_next[P_MOSI] = spi0_master_mode;
    end
    if (sel_reg[P_MISO] == pin_mux_pkg::fn_default) begin
      o_next[P_MISO] = spi0_miso_out;
      // a slave left unselected floats the line so other slaves can share it
      drive_next[P_MISO] = !spi0_master_mode && selected;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pad outputs, registered; costs one cycle of latency on spi outputs
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pin_o <= '0;
      pin_oe_b <= {NPINS{1'b1}}; // all pins inputs during reset
    end else begin
      pin_o <= o_next;
      pin_oe_b <= ~drive_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // inbound routing to the peripherals, idle values when not selected
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      quad0_index_input <= 1'b1;
      quad0_home_input <= 1'b1;
      timer_a_channel_two_in <= 1'b0;
      timer_a_channel_three_in <= 1'b0;
    end else begin
      quad0_index_input <= (sel_reg[P_INDEX] == pin_mux_pkg::fn_default) ? pin_i[P_INDEX] : 1'b1;
      quad0_home_input <= (sel_reg[P_HOME] == pin_mux_pkg::fn_default) ? pin_i[P_HOME] : 1'b1;
      timer_a_channel_two_in <= (sel_reg[P_INDEX] == pin_mux_pkg::fn_alternate) && pin_i[P_INDEX];
      timer_a_channel_three_in <= (sel_reg[P_HOME] == pin_mux_pkg::fn_alternate) && pin_i[P_HOME];
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      spi0_clock_in <= 1'b0;
      spi0_mosi_in <= 1'b0;
      spi0_miso_in <= 1'b0;
      spi0_selected <= 1'b0;
    end else begin
      // slave takes the clock from the pin, master sees its own clock
      spi0_clock_in <= (sel_reg[P_SCLK] == pin_mux_pkg::fn_default) && pin_i[P_SCLK];
      spi0_mosi_in <= (sel_reg[P_MOSI] == pin_mux_pkg::fn_default) && pin_i[P_MOSI];
      spi0_miso_in <= (sel_reg[P_MISO] == pin_mux_pkg::fn_default) && pin_i[P_MISO];
      spi0_selected <= selected;
    end
  end

  // gpio input readback, valid whatever the function
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      gpio_in <= '0;
    end else begin
      gpio_in <= pin_i;
    end
  end

endmodule : quad0_spi0_pin_mux
`default_nettype wire

/* dv/pin_mux_checker.sv */
// checker: pull-up, routing and spi pad relations of the pin mux
// bound to each mux instance; sees only its ports
`default_nettype none
module pin_mux_checker #(parameter int unsigned NPINS = 6) (
  input wire logic mclk, rst_b, sel_write, port_c_pullup_write, port_e_pullup_write,
  input wire logic [1:0] index_sel, home_sel, sclk_sel, mosi_sel, miso_sel, ss_sel,
  input wire logic [7:0] port_c_pullup_wdata, port_e_pullup_wdata,
  input wire logic [7:0] port_c_pullup_enable, port_e_pullup_enable,
  input wire logic [NPINS-1:0] pin_i, pin_o, pin_oe_b, pin_pullup,
  input wire logic timer_a_channel_two_oe, timer_a_channel_two_in, quad0_index_input,
  input wire logic spi0_master_mode, spi0_mosi_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [11:0] sel_reg;
  logic rdy_reg;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////////
  // copy of the select registers; rdy hides the first edge, whose past is in reset
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sel_reg <= 12'h000;
      rdy_reg <= 1'b0;
    end else begin
      rdy_reg <= 1'b1;
      if (sel_write) sel_reg <= {ss_sel, miso_sel, mosi_sel, sclk_sel, home_sel, index_sel};
    end
  end
  // a load lands in the register, then one edge later on the pads
  sequence s_pc_land;
    port_c_pullup_enable == $past(port_c_pullup_wdata) ##1
    pin_pullup[1:0] == $past(port_c_pullup_wdata[7:6], 2);
  endsequence
  sequence s_pe_land;
    port_e_pullup_enable == $past(port_e_pullup_wdata) ##1
    pin_pullup[5:2] == $past(port_e_pullup_wdata[7:4], 2);
  endsequence
  AST_PC_LOAD: assert property (port_c_pullup_write |=> s_pc_land)
    else $error("pc pull-up load");
  AST_PE_LOAD: assert property (port_e_pullup_write |=> s_pe_land)
    else $error("pe pull-up load");
  AST_PULLUP_MAP: assert property (pin_pullup ==
    $past({port_e_pullup_enable[7:4], port_c_pullup_enable[7:6]})) else $error("pull-up map");
  AST_INDEX_ROUTE: assert property (rdy_reg |-> quad0_index_input ==
    ($past(sel_reg[1:0]) == 2'h0 ? $past(pin_i[0]) : 1'b1)) else $error("index route");
  AST_TIMER_TWO: assert property (rdy_reg && $past(sel_reg[1:0]) == 2'h1 |->
    timer_a_channel_two_in == $past(pin_i[0]) && pin_oe_b[0] == !$past(timer_a_channel_two_oe))
    else $error("timer two path");
  AST_SCLK_DIR: assert property (rdy_reg && $past(sel_reg[5:4]) == 2'h0 |->
    pin_oe_b[2] == !$past(spi0_master_mode)) else $error("clock direction");
  AST_MOSI_OUT: assert property (rdy_reg && $past(sel_reg[7:6] == 2'h0 && spi0_master_mode) |->
    !pin_oe_b[3] && pin_o[3] == $past(spi0_mosi_out)) else $error("master-out path");
  AST_MISO_DRIVE: assert property (rdy_reg && $past(sel_reg[11:8] == 4'h0 && !spi0_master_mode) |->
    pin_oe_b[4] == $past(pin_i[5])) else $error("master-in drive");
endmodule : pin_mux_checker
bind quad0_spi0_pin_mux pin_mux_checker #(.NPINS(NPINS)) pin_mux_checker_i (.*);
`default_nettype wire

/* dv/spi_peer_model.sv */
// spi peer and encoder on the six pads, with pull-up resolution
// assumes the mclk domain; a peer-led frame is 16 mclk ticks
`default_nettype none
module spi_peer_model (
  input wire logic mclk,
  input wire logic as_master,
  input wire logic as_slave,
  input wire logic [1:0] enc,
  input wire logic [5:0] dut_o,
  input wire logic [5:0] dut_oe_b,
  input wire logic [5:0] pull_en,
  output logic [5:0] pin_i,
  output logic [7:0] rx
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] TX = 8'h3c;
  logic [5:0] drv, val, last = 6'h00;
  logic [3:0] ph = 4'h0;
  logic sk = 1'b0;
  // as master: next bit set while clock low, ss low all frame; as slave: echo on miso
  assign drv = {as_master, as_slave, {2{as_master}}, 2'h3};
  assign val = {1'b0, rx[0], TX[3'h7 - ph[3:1]], ph[0], enc};
  // released lines take the pull-up, else wander so a stale level never passes
  for (genvar k = 0; k < 6; k++) begin : g_pad
    assign pin_i[k] = !dut_oe_b[k] ? dut_o[k] : drv[k] ? val[k] : pull_en[k] | ~last[k];
  end
  // frame phase, and a shift on each rising pad clock
  always_ff @(posedge mclk) begin
    last <= pin_i;
    sk <= pin_i[2];
    ph <= as_master ? ph + 4'h1 : 4'h0;
    if (pin_i[2] && !sk) rx <= {rx[6:0], as_master ? pin_i[4] : pin_i[3]};
  end
endmodule : spi_peer_model
`default_nettype wire

/* dv/quad0_spi0_pin_mux_bench.sv */
// bench for the pin mux: reset, then pull-up rows, timer, gpio and spi cases
// assumes the checker bind and the spi peer model are compiled alongside
`default_nettype none
module quad0_spi0_pin_mux_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0, rst_b = 1'b0, sel_write = 1'b0, port_c_pullup_write = 1'b0;
  logic port_e_pullup_write = 1'b0, spi0_master_mode = 1'b0, spi0_clock_out = 1'b0;
  logic spi0_mosi_out = 1'b0, spi0_miso_out = 1'b1, timer_a_channel_two_out = 1'b0;
  logic timer_a_channel_two_oe = 1'b0, timer_a_channel_three_out = 1'b0;
  logic timer_a_channel_three_oe = 1'b0, as_master = 1'b0, as_slave = 1'b0;
  logic [1:0] index_sel = 2'h0, home_sel = 2'h0, sclk_sel = 2'h0, mosi_sel = 2'h0;
  logic [1:0] miso_sel = 2'h0, ss_sel = 2'h0, enc = 2'h2;
  logic [7:0] port_c_pullup_wdata = 8'hff, port_e_pullup_wdata = 8'hff, mb = 8'ha5;
  logic [7:0] port_c_pullup_enable, port_e_pullup_enable, rx;
  logic [5:0] gpio_out = 6'h3f, gpio_dir_out = 6'h15, gpio_in, pin_i, pin_o, pin_oe_b, pin_pullup;
  logic timer_a_channel_two_in, timer_a_channel_three_in, quad0_index_input, quad0_home_input;
  logic spi0_clock_in, spi0_mosi_in, spi0_miso_in, spi0_selected;
  logic [7:0] rc [5] = '{8'hbf, 8'h7f, 8'hff, 8'hff, 8'hff};
  logic [7:0] re [5] = '{8'hef, 8'hdf, 8'hbf, 8'h7f, 8'hff};
  logic [7:0] rp [5] = '{8'h3a, 8'h35, 8'h2f, 8'h1f, 8'h3f};
  int error_cnt = 0, checked = 0;
  quad0_spi0_pin_mux quad0_spi0_pin_mux_i (.*);
  spi_peer_model spi_peer_model_i (.mclk, .as_master, .as_slave, .enc, .dut_o(pin_o),
    .dut_oe_b(pin_oe_b), .pull_en(pin_pullup), .pin_i, .rx);
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task conclude();
    $display("checked %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  // one write loads every select; outputs settle two edges later
  task sel(input logic [1:0] a, input logic [1:0] b);
    @(posedge mclk);
    {index_sel, home_sel, sclk_sel, mosi_sel, miso_sel, ss_sel} <= {{2{a}}, {4{b}}};
    sel_write <= 1'b1;
    @(posedge mclk);
    sel_write <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
  endtask : sel
  ////////////////////////////////////////////////////////////////////////////////
  // clock, and a watchdog in case a case hangs
  initial forever #12.5 mclk = ~mclk;
  initial begin
    repeat (5000) @(posedge mclk);
    error_cnt++;
    conclude();
  end
  // main sequence
  initial begin
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chk(port_c_pullup_enable & port_e_pullup_enable, 8'hff);
    chk(8'(pin_oe_b), 8'h3f);
    chk(8'({quad0_home_input, quad0_index_input}), 8'h02);
    for (int i = 0; i < 5; i++) begin
      @(posedge mclk);
      {port_c_pullup_wdata, port_e_pullup_wdata} <= {rc[i], re[i]};
      {port_c_pullup_write, port_e_pullup_write} <= 2'h3;
      @(posedge mclk);
      {port_c_pullup_write, port_e_pullup_write} <= 2'h0;
      repeat (2) @(posedge mclk);
      #1;
      chk(8'(pin_pullup), rp[i]);
    end
    @(posedge mclk);
    {timer_a_channel_two_oe, timer_a_channel_two_out} <= 2'h3;
    sel(pin_mux_pkg::fn_alternate, pin_mux_pkg::fn_default);
    chk(8'({pin_oe_b[1:0], pin_o[0]}), 8'h05);
    chk(8'({timer_a_channel_three_in, quad0_index_input}), 8'h03);
    sel(pin_mux_pkg::fn_gpio, pin_mux_pkg::fn_gpio);
    chk(8'(pin_oe_b), 8'h2a);
    chk(8'(gpio_in), 8'h3f);
    // master: the bench plays the spi core, the peer collects the byte
    sel(pin_mux_pkg::fn_default, pin_mux_pkg::fn_default);
    @(posedge mclk);
    {spi0_master_mode, as_slave} <= 2'h3;
    for (int i = 7; i >= 0; i--) begin
      @(posedge mclk);
      {spi0_clock_out, spi0_mosi_out} <= {1'b0, mb[i]};
      @(posedge mclk);
      spi0_clock_out <= 1'b1;
    end
    repeat (3) @(posedge mclk);
    #1;
    chk(rx, 8'ha5);
    // slave: the peer runs a frame with ss low, then lets ss float to the pull-up
    @(posedge mclk);
    {spi0_master_mode, as_slave, as_master} <= 3'h1;
    repeat (9) @(posedge mclk);
    #1;
    chk(8'({spi0_selected, pin_oe_b[4]}), 8'h02);
    repeat (7) @(posedge mclk);
    as_master <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    chk(8'({spi0_selected, pin_oe_b[4]}), 8'h01);
    conclude();
  end
endmodule : quad0_spi0_pin_mux_bench
`default_nettype wire
